/* File: logic/hall_cfg_pkg.sv */
// Shared types and constants of the sensor configuration register block
package hall_cfg_pkg;

    localparam logic [7:0]  CONV_CFG_IDX = 8'h02;
    localparam logic [7:0]  INT_CFG_IDX  = 8'h03;
    localparam logic [31:0] CONV_WR_MASK = 32'h00FF_FFFF;
    localparam logic [31:0] INT_WR_MASK  = 32'h01FF_FFFF;
    localparam logic [31:0] CONV_RST     = 32'h0001_BFC0;
    localparam logic [31:0] INT_RST      = 32'h0000_0000;
    localparam int          MEAS_W       = 12;
    localparam int          THR_W        = 6;
    localparam int          AXES         = 3;
    localparam logic [1:0]  AXIS_X       = 2'h0;

    typedef enum logic [1:0] {PLATE_SINGLE, PLATE_DIFF, PLATE_COMMON, PLATE_ALT} plate_mode_t;
    typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_DUTY_CYCLE} power_state_t;

    // Conversion and bus word; enables and axes ordered z, y, x from the top
    typedef struct packed {
        logic [7:0]  rsvd;
        logic [2:0]  sample_rate_select;
        logic [1:0]  plate_mode;
        logic        crc_en;
        logic        addr_from_store;
        logic [6:0]  stored_addr;
        logic        io_low_thr;
        logic [2:0]  ch_en;
        logic        int_latch_en;
        logic [4:0]  customer;
    } conv_cfg_t;

    // Interrupt word
    typedef struct packed {
        logic [6:0]            rsvd;
        logic                  signed_thr;
        logic                  delta_mode;
        logic                  nv_event_status;
        logic                  nv_record_en;
        logic [2:0]            int_en;
        logic [2:0][THR_W-1:0] thr;
    } int_cfg_t;

    typedef logic [AXES-1:0][MEAS_W-1:0] meas_set_t;

endpackage

/* File: logic/axis_conversion_sequencer.sv */
// Round-robin conversion sequencer over enabled axes with plate mode selection
`timescale 1ns/1ps
`default_nettype none
module axis_conversion_sequencer
    import hall_cfg_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       run_i,
    input  wire logic [2:0] ch_en_i,
    input  wire logic [1:0] plate_mode_i,
    input  wire logic       conv_done_i,
    output logic            conv_run_o,
    output logic [1:0]      conv_axis_o,
    output logic [1:0]      conv_plate_o
);
    logic [1:0] axis_q, axis_d;
    logic [2:0] alt_q, alt_d;
    logic [1:0] cand;

    always_comb begin
        axis_d = axis_q;
        alt_d  = alt_q;
        cand   = axis_q;
        if (!ch_en_i[axis_q] || conv_done_i) begin
            for (int i = 3; i >= 1; i--) begin
                cand = 2'((32'(axis_q) + i) % 3);
                if (ch_en_i[cand]) axis_d = cand;
            end
        end
        if (conv_done_i && run_i) alt_d[axis_q] = ~alt_q[axis_q];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            axis_q <= AXIS_X;
            alt_q  <= 3'h0;
        end else begin
            axis_q <= axis_d;
            alt_q  <= alt_d;
        end
    end

    assign conv_run_o   = run_i && ch_en_i[axis_q] && (axis_q != 2'h3);
    assign conv_axis_o  = axis_q;
    assign conv_plate_o = (plate_mode_i == PLATE_ALT) ? (alt_q[axis_q] ? PLATE_COMMON : PLATE_DIFF)
                                                      : plate_mode_i;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    alt_toggle_a: assert property ((plate_mode_i == PLATE_ALT) && conv_done_i && run_i
        |=> (alt_q ^ $past(alt_q)) == (3'h1 << $past(axis_q)))
        else $error("alternating plate mode did not switch");
    skip_disabled_a: assert property (run_i && (ch_en_i != 3'h0) && $stable(ch_en_i) |-> conv_run_o)
        else $error("sequencer parked on a disabled axis");
endmodule
`default_nettype wire

/* File: logic/axis_threshold_compare.sv */
// Per-axis interrupt comparison in threshold or delta mode
`timescale 1ns/1ps
`default_nettype none
module axis_threshold_compare
    import hall_cfg_pkg::*;
#(
    parameter int THR_SHIFT = 6
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  meas_valid_i,
    input  wire meas_set_t             meas_i,
    input  wire int_cfg_t              cfg_i,
    input  wire logic                  duty_cycle_i,
    output logic                       event_o,
    output logic                       event_new_o
);
    localparam int CW = MEAS_W + THR_W + THR_SHIFT + 2;

    meas_set_t          base_q, base_d;
    logic               have_q, have_d, ev_q, ev_d, new_q, new_d;
    logic [AXES-1:0]    hit;

    for (genvar a = 0; a < AXES; a++) begin : g_axis
        logic signed [CW-1:0] v, t;
        always_comb begin
            v = CW'($signed(meas_i[a])) - (cfg_i.delta_mode ? CW'($signed(base_q[a])) : '0);
            t = cfg_i.signed_thr ? CW'($signed(cfg_i.thr[a])) <<< THR_SHIFT
                                 : CW'({1'b0, cfg_i.thr[a]}) <<< THR_SHIFT;
            if (!cfg_i.int_en[a])
                hit[a] = 1'b0;
            else if (!cfg_i.signed_thr)
                hit[a] = (v > t) || (v < -t);
            else
                hit[a] = (t >= 0) ? (v > t) : (v < t);
        end
    end

    always_comb begin
        base_d = base_q;
        have_d = have_q && duty_cycle_i;
        ev_d   = ev_q;
        new_d  = 1'b0;
        if (meas_valid_i) begin
            if (cfg_i.delta_mode && !have_q) begin
                have_d = duty_cycle_i;
                base_d = meas_i;
                ev_d   = 1'b0;
            end else begin
                ev_d  = |hit;
                new_d = |hit;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            base_q <= '0;
            have_q <= 1'b0;
            ev_q   <= 1'b0;
            new_q  <= 1'b0;
        end else begin
            base_q <= base_d;
            have_q <= have_d;
            ev_q   <= ev_d;
            new_q  <= new_d;
        end
    end

    assign event_o     = ev_q;
    assign event_new_o = new_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    no_axis_event_a: assert property (meas_valid_i && (cfg_i.int_en == 3'h0) |=> !event_new_o)
        else $error("event raised with all axes excluded");
    delta_base_a: assert property (meas_valid_i && cfg_i.delta_mode && !have_q && duty_cycle_i
        |=> have_q && (base_q == $past(meas_i)) && !event_new_o)
        else $error("delta baseline not captured");
endmodule
`default_nettype wire

/* File: logic/hall_sensor_config_regs.sv */
// Configuration and interrupt register bank of the three-axis field sensor
`timescale 1ns/1ps
`default_nettype none

module hall_sensor_config_regs
    import hall_cfg_pkg::*;
#(
    parameter int THR_SHIFT = 6
) (
    input  wire logic          ref_clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic [31:0]   reg_wdata_i,
    output logic [31:0]        reg_rdata_o,
    output logic               reg_ack_o,
    output logic               reg_err_o,
    input  wire logic          customer_access_i,
    input  wire logic          nvm_ready_i,
    input  wire logic [31:0]   nvm_conv_word_i,
    input  wire logic [31:0]   nvm_int_word_i,
    output logic               nvm_prog_req_o,
    output logic [7:0]         nvm_prog_addr_o,
    output logic [31:0]        nvm_prog_data_o,
    input  wire logic          nvm_prog_done_i,
    output logic               cfg_loaded_o,
    output logic [2:0]         sample_rate_select_o,
    output logic               crc_en_o,
    output logic               io_low_thr_o,
    input  wire logic [6:0]    addr_pin_code_i,
    input  wire logic          addr_pins_at_supply_i,
    output logic [6:0]         bus_addr_o,
    input  wire power_state_t  power_state_i,
    input  wire logic          conv_done_i,
    output logic               conv_run_o,
    output logic [1:0]         conv_axis_o,
    output logic [1:0]         conv_plate_o,
    input  wire logic          meas_valid_i,
    input  wire meas_set_t     meas_i,
    input  wire logic          int_clear_i,
    output logic               int_flag_o,
    output logic               int_n_o,
    output logic               int_write_busy_o
);
    typedef enum logic {ST_LOAD, ST_RUN} bank_state_t;

    bank_state_t st_q, st_d;
    conv_cfg_t   conv_q, conv_d;
    int_cfg_t    int_q, int_d;
    logic [31:0] rdata_q, rdata_d, pdata_q, pdata_d;
    logic [7:0]  paddr_q, paddr_d;
    logic [6:0]  baddr_q, baddr_d;
    logic        ack_q, ack_d, err_q, err_d;
    logic        preq_q, preq_d, rbusy_q, rbusy_d, rpend_q, rpend_d;
    logic        flag_q, flag_d;
    logic        is_conv, is_int, wr_ok, rec_evt, prog_free;
    logic        ev_lvl, ev_new, run;

    assign run     = (st_q == ST_RUN) && (power_state_i != PWR_SLEEP);
    assign is_conv = (reg_addr_i == CONV_CFG_IDX);
    assign is_int  = (reg_addr_i == INT_CFG_IDX);
    assign wr_ok   = reg_wr_i && customer_access_i && (st_q == ST_RUN) && !preq_q && (is_conv || is_int);
    assign rec_evt = ev_new && int_q.nv_record_en && (st_q == ST_RUN);

    axis_conversion_sequencer u_seq (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .run_i        (run),
        .ch_en_i      (conv_q.ch_en),
        .plate_mode_i (conv_q.plate_mode),
        .conv_done_i  (conv_done_i),
        .conv_run_o   (conv_run_o),
        .conv_axis_o  (conv_axis_o),
        .conv_plate_o (conv_plate_o)
    );

    axis_threshold_compare #(
        .THR_SHIFT (THR_SHIFT)
    ) u_cmp (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .meas_valid_i (meas_valid_i && (st_q == ST_RUN)),
        .meas_i       (meas_i),
        .cfg_i        (int_q),
        .duty_cycle_i (power_state_i == PWR_DUTY_CYCLE),
        .event_o      (ev_lvl),
        .event_new_o  (ev_new)
    );

    // Working copies, host access and loading
    always_comb begin
        st_d    = st_q;
        conv_d  = conv_q;
        int_d   = int_q;
        ack_d   = reg_wr_i || reg_rd_i;
        err_d   = (reg_wr_i && !wr_ok) || (reg_rd_i && !(is_conv || is_int));
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            if (is_conv)
                rdata_d = 32'(conv_q);
            else if (is_int)
                rdata_d = 32'(int_q);
            else
                rdata_d = 32'h0000_0000;
        end
        case (st_q)
            ST_LOAD: begin
                if (nvm_ready_i) begin
                    conv_d = conv_cfg_t'(nvm_conv_word_i & CONV_WR_MASK);
                    int_d  = int_cfg_t'(nvm_int_word_i & INT_WR_MASK);
                    st_d   = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_ok && is_conv)
                    conv_d = conv_cfg_t'(reg_wdata_i & CONV_WR_MASK);
                if (wr_ok && is_int)
                    int_d = int_cfg_t'(reg_wdata_i & INT_WR_MASK);
            end
            default: st_d = ST_LOAD;
        endcase
        if (rec_evt)
            int_d.nv_event_status = 1'b1;
    end

    // Non-volatile programming of host writes and event records
    always_comb begin
        preq_d    = preq_q;
        paddr_d   = paddr_q;
        pdata_d   = pdata_q;
        rbusy_d   = rbusy_q;
        rpend_d   = rpend_q || rec_evt;
        prog_free = !preq_q || nvm_prog_done_i;
        if (preq_q && nvm_prog_done_i) begin
            preq_d  = 1'b0;
            rbusy_d = 1'b0;
        end
        if (wr_ok) begin
            preq_d  = 1'b1;
            paddr_d = reg_addr_i;
            pdata_d = is_conv ? 32'(conv_d) : 32'(int_d);
            rbusy_d = 1'b0;
        end else if (rpend_d && prog_free) begin
            preq_d  = 1'b1;
            paddr_d = INT_CFG_IDX;
            pdata_d = 32'(int_d);
            rbusy_d = 1'b1;
            rpend_d = 1'b0;
        end
    end

    // Interrupt flag and bus address selection
    always_comb begin
        if (conv_q.int_latch_en)
            flag_d = (flag_q && !int_clear_i) || ev_new;
        else
            flag_d = ev_lvl;
        if (conv_q.addr_from_store || addr_pins_at_supply_i)
            baddr_d = conv_q.stored_addr;
        else
            baddr_d = addr_pin_code_i;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q    <= ST_LOAD;
            conv_q  <= conv_cfg_t'(CONV_RST);
            int_q   <= int_cfg_t'(INT_RST);
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            preq_q  <= 1'b0;
            paddr_q <= 8'h00;
            pdata_q <= 32'h0000_0000;
            rbusy_q <= 1'b0;
            rpend_q <= 1'b0;
            flag_q  <= 1'b0;
            baddr_q <= 7'h00;
        end else begin
            st_q    <= st_d;
            conv_q  <= conv_d;
            int_q   <= int_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
            preq_q  <= preq_d;
            paddr_q <= paddr_d;
            pdata_q <= pdata_d;
            rbusy_q <= rbusy_d;
            rpend_q <= rpend_d;
            flag_q  <= flag_d;
            baddr_q <= baddr_d;
        end
    end

    assign reg_rdata_o          = rdata_q;
    assign reg_ack_o            = ack_q;
    assign reg_err_o            = err_q;
    assign nvm_prog_req_o       = preq_q;
    assign nvm_prog_addr_o      = paddr_q;
    assign nvm_prog_data_o      = pdata_q;
    assign cfg_loaded_o         = (st_q == ST_RUN);
    assign sample_rate_select_o = conv_q.sample_rate_select;
    assign crc_en_o             = conv_q.crc_en;
    assign io_low_thr_o         = conv_q.io_low_thr;
    assign bus_addr_o           = baddr_q;
    assign int_flag_o           = flag_q;
    assign int_n_o              = ~flag_q;
    assign int_write_busy_o     = rbusy_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    locked_write_a: assert property (reg_wr_i && !customer_access_i && is_conv && !rec_evt && cfg_loaded_o
        |=> $stable(conv_q) ##0 reg_err_o)
        else $error("write accepted without customer access");
    write_lands_a: assert property (wr_ok && is_conv
        |=> (32'(conv_q) == ($past(reg_wdata_i) & CONV_WR_MASK)) && nvm_prog_req_o)
        else $error("accepted write not stored or not programmed");
    load_copy_a: assert property ((st_q == ST_LOAD) && nvm_ready_i
        |=> cfg_loaded_o && (32'(int_q) == ($past(nvm_int_word_i) & INT_WR_MASK)))
        else $error("stored words not loaded into working copies");
    latch_hold_a: assert property (conv_q.int_latch_en && int_flag_o && !int_clear_i
        ##1 conv_q.int_latch_en |-> int_flag_o && !int_n_o)
        else $error("latched interrupt released without clear");
    clear_release_a: assert property (conv_q.int_latch_en && int_flag_o && int_clear_i && !ev_new
        |=> !int_flag_o && int_n_o)
        else $error("latched interrupt not released by clear");
    event_sets_a: assert property (ev_new |=> int_flag_o)
        else $error("interrupt event lost");
    nv_record_a: assert property (rec_evt && !nvm_prog_req_o && !wr_ok |=> int_q.nv_event_status ##[0:2] (nvm_prog_req_o
        && (nvm_prog_addr_o == INT_CFG_IDX) && nvm_prog_data_o[22]))
        else $error("event not recorded in stored status");
    addr_select_a: assert property (conv_q.addr_from_store && $stable(conv_q)
        |=> bus_addr_o == $past(conv_q.stored_addr))
        else $error("pins not bypassed for bus address");
    pin_addr_a: assert property (!conv_q.addr_from_store && !addr_pins_at_supply_i
        |=> bus_addr_o == $past(addr_pin_code_i))
        else $error("pin address not used");

    ack_timing_a: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("access not acknowledged");
    unmapped_read_a: assert property (reg_rd_i && !is_conv && !is_int |=> reg_err_o)
        else $error("unmapped read not refused");
    read_data_a: assert property (reg_rd_i && is_conv |=> reg_rdata_o == 32'($past(conv_q)))
        else $error("read data wrong");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without read");
    busy_refuse_a: assert property (reg_wr_i && nvm_prog_req_o |=> reg_err_o && $stable(conv_q))
        else $error("write accepted while programming");
    load_refuse_a: assert property (reg_wr_i && !cfg_loaded_o |=> reg_err_o)
        else $error("write accepted while loading");
    write_int_a: assert property (wr_ok && is_int && !rec_evt
        |=> 32'(int_q) == ($past(reg_wdata_i) & INT_WR_MASK))
        else $error("interrupt word write not stored");
    level_follow_a: assert property (!conv_q.int_latch_en |=> int_flag_o == $past(ev_lvl))
        else $error("unlatched flag not following event");
    sleep_stop_a: assert property ((power_state_i == PWR_SLEEP) |-> !conv_run_o)
        else $error("conversion running in sleep");
    record_busy_a: assert property (rec_evt && !nvm_prog_req_o && !wr_ok |=> int_write_busy_o)
        else $error("record write not flagged busy");
    addr_supply_a: assert property (addr_pins_at_supply_i |=> bus_addr_o == $past(conv_q.stored_addr))
        else $error("supply pins not using stored address");
endmodule
`default_nettype wire

/* File: bench/nvm_store_model.sv */
// Stored-word memory model answering load and programming requests
`timescale 1ns/1ps
`default_nettype none
module nvm_store_model #(
    parameter logic [31:0] CONV_IMG = 32'h0045_BDC0,
    parameter logic [31:0] INT_IMG  = 32'h0000_0000
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,
    input  wire logic        prog_req_i,
    input  wire logic [7:0]  prog_addr_i,
    input  wire logic [31:0] prog_data_i,
    output logic             ready_o,
    output logic [31:0]      conv_word_o,
    output logic [31:0]      int_word_o,
    output logic             prog_done_o
);
    logic [31:0] conv_q = CONV_IMG;
    logic [31:0] int_q  = INT_IMG;
    logic [4:0]  ld_cnt;
    logic [4:0]  pg_cnt;
    logic        served;

    // Words show only once ready; inverted image while loading
    assign conv_word_o = ready_o ? conv_q : ~conv_q;
    assign int_word_o  = ready_o ? int_q : ~int_q;

    always @(posedge ref_clk_i) begin
        prog_done_o <= 1'b0;
        if (!rst_n_i) begin
            ready_o <= 1'b0;
            ld_cnt  <= 5'h00;
            pg_cnt  <= 5'h00;
            served  <= 1'b0;
        end else begin
            if (ld_cnt == 5'h0C) ready_o <= 1'b1;
            else ld_cnt <= ld_cnt + 5'h01;
            if (!prog_req_i) begin
                pg_cnt <= 5'h00;
                served <= 1'b0;
            end else if (!served && pg_cnt == (slow_i ? 5'h14 : 5'h02)) begin
                prog_done_o <= 1'b1;
                served      <= 1'b1;
                if (prog_addr_i == 8'h02) conv_q <= prog_data_i;
                else int_q <= prog_data_i;
            end else if (!served) begin
                pg_cnt <= pg_cnt + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/hall_sensor_config_interrupt_regs_tb.sv */
// Self-checking bench of the sensor configuration register bank
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_config_interrupt_regs_tb
    import hall_cfg_pkg::*;
;
    typedef struct packed {logic [7:0] addr; logic [31:0] data; logic acc; logic err;} wr_row_t;
    typedef struct packed {logic [31:0] intw; power_state_t ps; logic [11:0] x; logic flag;} int_row_t;

    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, acc = 1'b0, slow = 1'b0;
    logic [7:0] addr = 8'h00, paddr;
    logic [31:0] wdata = 32'h0, rdata, nconv, nint, pdata, rd_val;
    logic ack, err, nrdy, preq, pdone, loaded, crc, iothr, crun, flag, int_n, wbusy;
    logic [2:0] srate;
    logic [6:0] pin_code = 7'h15, baddr;
    logic at_supply = 1'b0, cdone = 1'b0, mvalid = 1'b0, iclr = 1'b0;
    logic [1:0] caxis, cplate, pa;
    logic [1:0] lastp [4];
    power_state_t ps = PWR_ACTIVE;
    meas_set_t meas = '0;
    logic [31:0] sh2 = 32'h0045_BDC0, sh3 = 32'h0;
    int error_cnt = 0, tests_run = 0, cyc = 0, n;

    wr_row_t rows [7] = '{'{8'h02, 32'hFFFF_FFFF, 1'b0, 1'b1}, '{8'h05, 32'h0000_0001, 1'b1, 1'b1},
        '{8'h02, 32'hFFFF_FFFF, 1'b1, 1'b0}, '{8'h03, 32'hFE7F_FFFF, 1'b1, 1'b0},
        '{8'h02, 32'h0025_7C1F, 1'b1, 1'b0}, '{8'h02, 32'h00E0_0200, 1'b1, 1'b0},
        '{8'h02, 32'h0008_0340, 1'b1, 1'b0}};
    int_row_t irows [11] = '{'{32'h0004_0002, PWR_ACTIVE, 12'h081, 1'b1},
        '{32'h0004_0002, PWR_ACTIVE, 12'hF7F, 1'b1}, '{32'h0004_0002, PWR_ACTIVE, 12'h064, 1'b0},
        '{32'h0008_0002, PWR_ACTIVE, 12'h081, 1'b0}, '{32'h0104_003E, PWR_ACTIVE, 12'hF7F, 1'b1},
        '{32'h0104_003E, PWR_ACTIVE, 12'h081, 1'b0}, '{32'h0104_0002, PWR_ACTIVE, 12'hF7F, 1'b0},
        '{32'h0104_0002, PWR_ACTIVE, 12'h081, 1'b1}, '{32'h0084_0002, PWR_DUTY_CYCLE, 12'h3E8, 1'b0},
        '{32'h0084_0002, PWR_DUTY_CYCLE, 12'h44C, 1'b0}, '{32'h0084_0002, PWR_DUTY_CYCLE, 12'h4B0, 1'b1}};

    always #5 clk = ~clk;

    hall_sensor_config_regs i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
        .customer_access_i(acc), .nvm_ready_i(nrdy), .nvm_conv_word_i(nconv), .nvm_int_word_i(nint),
        .nvm_prog_req_o(preq), .nvm_prog_addr_o(paddr), .nvm_prog_data_o(pdata), .nvm_prog_done_i(pdone),
        .cfg_loaded_o(loaded), .sample_rate_select_o(srate), .crc_en_o(crc), .io_low_thr_o(iothr),
        .addr_pin_code_i(pin_code), .addr_pins_at_supply_i(at_supply), .bus_addr_o(baddr),
        .power_state_i(ps), .conv_done_i(cdone), .conv_run_o(crun), .conv_axis_o(caxis),
        .conv_plate_o(cplate), .meas_valid_i(mvalid), .meas_i(meas), .int_clear_i(iclr),
        .int_flag_o(flag), .int_n_o(int_n), .int_write_busy_o(wbusy));

    nvm_store_model i_nvm (.ref_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .prog_req_i(preq),
        .prog_addr_i(paddr), .prog_data_i(pdata), .ready_o(nrdy), .conv_word_o(nconv),
        .int_word_o(nint), .prog_done_o(pdone));

    task finish_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // One strobe, answer one cycle later; accepted writes wait for programming
    task access(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        step(1);
        wr = 1'b0;
        rd = 1'b0;
        rd_val = rdata;
        check(ack, 1'b1);
        check(err, e);
        if (w && !e) begin
            check(paddr, a);
            check(pdata, d & (a == 8'h02 ? CONV_WR_MASK : INT_WR_MASK));
            n = 0;
            while (preq === 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            check(n < 100, 1'b1);
        end
        step(1);
    endtask

    task meas_x(input logic [11:0] x);
        meas = {24'h0, x};
        mvalid = 1'b1;
        step(1);
        mvalid = 1'b0;
        step(3);
    endtask

    task wait_loaded;
        n = 0;
        while (loaded !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        check(n < 100, 1'b1);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        step(10);
        check({flag, int_n, loaded, ack, preq}, 5'b01000);
        check({srate, iothr}, 4'b0001);
        rst_n = 1'b1;
        acc = 1'b1;
        access(1'b1, 8'h02, 32'h0, 1'b1);
        wait_loaded();
        check({loaded, srate, crc, iothr}, 6'b1_010_10);
        check(cplate, 2'h0);
        step(2);
        check(baddr, 7'h15);
        for (int i = 0; i < 7; i++) begin
            acc = rows[i].acc;
            access(1'b1, rows[i].addr, rows[i].data, rows[i].err);
            if (!rows[i].err && rows[i].addr == 8'h02) sh2 = rows[i].data & CONV_WR_MASK;
            if (!rows[i].err && rows[i].addr == 8'h03) sh3 = rows[i].data & INT_WR_MASK;
            access(1'b0, 8'h02, 32'h0, 1'b0);
            check(rd_val, sh2);
            access(1'b0, 8'h03, 32'h0, 1'b0);
            check(rd_val, sh3);
            check({srate, crc, iothr}, {sh2[23:21], sh2[18], sh2[9]});
        end
        access(1'b0, 8'h05, 32'h0, 1'b1);
        // Conversion sequencing over Z and X in alternating plate mode
        access(1'b1, 8'h02, 32'h0018_0340, 1'b0);
        for (int i = 0; i < 6; i++) begin
            check({crun, caxis == 2'h1}, 2'b10);
            if (i > 0) check(caxis, pa == 2'h0 ? 2'h2 : 2'h0);
            if (i > 1) check(cplate, lastp[caxis] == 2'h1 ? 2'h2 : 2'h1);
            lastp[caxis] = cplate;
            pa = caxis;
            cdone = 1'b1;
            step(1);
            cdone = 1'b0;
            step(1);
        end
        access(1'b1, 8'h02, 32'h0008_0340, 1'b0);
        check(cplate, 2'h1);
        ps = PWR_SLEEP;
        step(2);
        check(crun, 1'b0);
        ps = PWR_ACTIVE;
        // Bus address source
        access(1'b1, 8'h02, 32'h0002_A9C0, 1'b0);
        step(2);
        check(baddr, 7'h2A);
        access(1'b1, 8'h02, 32'h0000_A9C0, 1'b0);
        step(2);
        check(baddr, 7'h15);
        at_supply = 1'b1;
        step(2);
        check(baddr, 7'h2A);
        // Threshold, signed, axis enable and delta comparisons
        for (int i = 0; i < 11; i++) begin
            if (irows[i].intw !== sh3) access(1'b1, 8'h03, irows[i].intw, 1'b0);
            sh3 = irows[i].intw;
            ps = irows[i].ps;
            meas_x(irows[i].x);
            check({flag, int_n}, {irows[i].flag, !irows[i].flag});
        end
        ps = PWR_ACTIVE;
        // Latched flag and its clear
        access(1'b1, 8'h02, 32'h0000_0260, 1'b0);
        access(1'b1, 8'h03, 32'h0004_0002, 1'b0);
        meas_x(12'h081);
        meas_x(12'h000);
        check({flag, int_n}, 2'b10);
        iclr = 1'b1;
        step(1);
        iclr = 1'b0;
        step(1);
        check({flag, int_n}, 2'b01);
        // Event recording into stored status, slow programming
        access(1'b1, 8'h03, 32'h0024_0002, 1'b0);
        slow = 1'b1;
        meas_x(12'h081);
        check(wbusy, 1'b1);
        n = 0;
        while (wbusy === 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        check(n < 100, 1'b1);
        access(1'b0, 8'h03, 32'h0, 1'b0);
        check(rd_val, 32'h0064_0002);
        // Second reset reloads the programmed words
        rst_n = 1'b0;
        step(2);
        check({flag, int_n, loaded}, 3'b010);
        rst_n = 1'b1;
        wait_loaded();
        access(1'b0, 8'h02, 32'h0, 1'b0);
        check(rd_val, 32'h0000_0260);
        access(1'b0, 8'h03, 32'h0, 1'b0);
        check(rd_val, 32'h0064_0002);
        finish_test();
    end
endmodule
`default_nettype wire
